// file: inc/twc_pkg.sv
// Types shared by the two-wire controller.
// Assumes the register header supplies all numeric constants.
package twc_pkg;
  typedef enum logic [2:0] {
    TWC_IDLE  = 3'b000,
    TWC_BYTE  = 3'b001,
    TWC_HOLD  = 3'b010,
    TWC_MCOND = 3'b011
  } twc_state_t;

  typedef struct packed {
    logic addr_ack_or_general_call;
    logic byte_done;
    logic stop;
    logic sel;
    logic lost;
    logic busy;
    logic tx;
    logic ack_rx;
  } twc_status_t;
endpackage : twc_pkg

// file: inc/twc_regs.svh
// Register map, field positions and reset values of the two-wire controller.
// Assumes a 32-bit APB slave; register index times four is the byte address.
`ifndef TWC_REGS_SVH
`define TWC_REGS_SVH
`define TWC_IDX_OWN_ALT   10'h0D6
`define TWC_IDX_OWN       10'h0D7
`define TWC_IDX_MODE      10'h0DA
`define TWC_IDX_STATUS    10'h0DB
`define TWC_IDX_LOW       10'h0DC
`define TWC_IDX_HIGH      10'h0DD
`define TWC_IDX_HOLD      10'h0DE
`define TWC_IDX_DATA      10'h0DF
`define TWC_RST_OWN       8'h00
`define TWC_RST_LOW       8'h3F
`define TWC_RST_HIGH      8'h3F
`define TWC_RST_HOLD      8'h01
`define TWC_RST_DATA      8'hFF
`define TWC_MODE_IRQ      7
`define TWC_MODE_EN       6
`define TWC_MODE_SRST     5
`define TWC_MODE_IRQEN    4
`define TWC_MODE_ACK_ENABLE    3
`define TWC_MODE_STOP     1
`define TWC_MODE_START    0
`define TWC_CNT_W         10
`define TWC_LOW_ADD       10'h001
`define TWC_HIGH_ADD      10'h003
`define TWC_ADDR_ACK_OR_GENERAL_CALL_ADDR    8'h00
`define TWC_ACK_BIT       4'h8
`define TWC_END_BIT       4'h9
`endif

// file: logic/twc_top.sv
// Two-wire master/slave controller with APB register access.
// Assumes open-drain pads outside and SCL/SDA asynchronous to pclk.
//
// Notes on behaviour
// - Interrupt flag set on every interrupt event
// - Block enable gates all controller activity but the busy flag
// - Soft reset reinitialises core, self-clearing
// - Interrupt enable gates the interrupt output
// - Ack enable pulls SDA low at ninth
// - Ack own address, general call, received bytes
// - Stop request makes master send STOP
// - Start request sends START or repeated START
// - Bit 7: address ack or general call
// - Byte done set after each byte
// - Stop detected flag on bus STOP
// - Slave selected flag when addressed
// - Arbitration lost flag, mastership dropped
// - Busy between START and STOP
// - Direction bit one while transmitting
// - Ack received sampled at ninth period
// - Hold SCL low after non-stop events
// - Status write clears flags, releases SCL
// - SCL low lasts four times low plus one
// - SCL high lasts four times high plus three
// - SDA changes hold plus one after fall
// - Data register shifts out and collects bytes
// - Own address bits 7:1, bit 0 general call
// - Match without ack enable returns to idle
//
// Implementation choice: register access over APB.
`include "twc_regs.svh"
module twc_top
  import twc_pkg::*;
(
  // Clock and reset
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // Two-wire pins
  input  wire  logic        scl_in,
  output logic              scl_out,
  output logic              scl_oe_n,
  input  wire  logic        sda_in,
  output logic              sda_out,
  output logic              sda_oe_n,
  // Interrupt
  output logic              irq
);
  localparam logic [`TWC_CNT_W-1:0] CNT_ZERO = '0;

  logic                  scl_m_ff, scl_s_ff, scl_d_ff;
  logic                  sda_m_ff, sda_s_ff, sda_d_ff;
  logic                  pready_ff, pslverr_ff, irq_ff, pin_lo_ff;
  logic [31:0]           prdata_ff;
  logic [7:0]            own_ff, alt_ff, low_ff, high_ff, hold_ff;
  logic                  en_ff, irqen_ff, ack_enable_ff;
  logic                  irq_flag_ff, start_req_ff, stop_req_ff, master_ff;
  logic [7:0]            data_ff, hold_cnt_ff;
  twc_status_t           st_ff;
  twc_state_t            state_ff;
  logic [`TWC_CNT_W-1:0] cnt_ff;
  logic [1:0]            phase_ff;
  logic [3:0]            bit_ff;
  logic                  scl_low_ff, sda_low_ff, pend_ff, pend_val_ff;
  logic                  addr_ph_ff, slv_act_ff, cond_stop_ff;
  logic                  acc, wr, wr_mode, wr_stat, wr_data, soft_rst, mapped;
  logic [9:0]            idx;
  logic [7:0]            rd_val;
  logic                  scl_rise, scl_fall, start_det, stop_det, tx_bit, match;
  logic [`TWC_CNT_W-1:0] low_load, high_load;

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_m_ff <= scl_in;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
    end
  end

  assign scl_rise  = scl_s_ff & ~scl_d_ff;
  assign scl_fall  = ~scl_s_ff & scl_d_ff;
  assign start_det = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  assign stop_det  = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
  assign low_load  = {2'b00, low_ff} + {2'b00, low_ff} + {2'b00, low_ff} + {2'b00, low_ff}
                     + `TWC_LOW_ADD;
  assign high_load = {2'b00, high_ff} + {2'b00, high_ff} + {2'b00, high_ff} + {2'b00, high_ff}
                     + `TWC_HIGH_ADD;
  assign tx_bit    = addr_ph_ff ? master_ff : st_ff.tx;
  assign match     = ((data_ff[7:1] != 7'h00) & ((data_ff[7:1] == own_ff[7:1]) | (data_ff[7:1] == alt_ff[7:1])))
                   | ((data_ff == `TWC_ADDR_ACK_OR_GENERAL_CALL_ADDR) & (own_ff[0] | alt_ff[0]));

  // APB decode
  assign idx      = paddr[11:2];
  assign acc      = psel & penable & pready_ff;
  assign wr       = acc & pwrite & mapped;
  assign wr_mode  = wr & (idx == `TWC_IDX_MODE);
  assign wr_stat  = wr & (idx == `TWC_IDX_STATUS);
  assign wr_data  = wr & (idx == `TWC_IDX_DATA);
  assign soft_rst = wr_mode & pwdata[`TWC_MODE_SRST];

  always_comb
  begin
    mapped = 1'b1;
    rd_val = 8'h00;
    case (idx)
      `TWC_IDX_OWN_ALT: rd_val = alt_ff;
      `TWC_IDX_OWN:     rd_val = own_ff;
      `TWC_IDX_MODE:    rd_val = {irq_flag_ff, en_ff, 1'b0, irqen_ff, ack_enable_ff,
                                  master_ff, stop_req_ff, start_req_ff};
      `TWC_IDX_STATUS:  rd_val = st_ff;
      `TWC_IDX_LOW:     rd_val = low_ff;
      `TWC_IDX_HIGH:    rd_val = high_ff;
      `TWC_IDX_HOLD:    rd_val = hold_ff;
      `TWC_IDX_DATA:    rd_val = data_ff;
      default:          mapped = 1'b0;
    endcase
  end

  // APB answer, one wait-free access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= psel & ~penable;
      pslverr_ff <= psel & ~penable & (~mapped | (paddr[1:0] != 2'b00));
      prdata_ff  <= (psel & ~penable & ~pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      own_ff   <= `TWC_RST_OWN;
      alt_ff   <= `TWC_RST_OWN;
      low_ff   <= `TWC_RST_LOW;
      high_ff  <= `TWC_RST_HIGH;
      hold_ff  <= `TWC_RST_HOLD;
      en_ff    <= 1'b0;
      irqen_ff <= 1'b0;
      ack_enable_ff <= 1'b0;
    end
    else if (wr)
    begin
      case (idx)
        `TWC_IDX_OWN_ALT: alt_ff <= pwdata[7:0];
        `TWC_IDX_OWN:     own_ff <= pwdata[7:0];
        `TWC_IDX_LOW:     low_ff <= pwdata[7:0];
        `TWC_IDX_HIGH:    high_ff <= pwdata[7:0];
        `TWC_IDX_HOLD:    hold_ff <= pwdata[7:0];
        `TWC_IDX_MODE:
        begin
          en_ff    <= pwdata[`TWC_MODE_EN];
          irqen_ff <= pwdata[`TWC_MODE_IRQEN];
          ack_enable_ff <= pwdata[`TWC_MODE_ACK_ENABLE];
        end
        default:          own_ff <= own_ff;
      endcase
    end
  end

  // Interrupt output and pin drivers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_ff    <= 1'b0;
      pin_lo_ff <= 1'b0;
    end
    else
    begin
      irq_ff    <= irq_flag_ff & irqen_ff;
      pin_lo_ff <= 1'b0;
    end
  end

  // Bus engine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff     <= TWC_IDLE;
      st_ff        <= '0;
      data_ff      <= `TWC_RST_DATA;
      irq_flag_ff  <= 1'b0;
      start_req_ff <= 1'b0;
      stop_req_ff  <= 1'b0;
      master_ff    <= 1'b0;
      cnt_ff       <= CNT_ZERO;
      phase_ff     <= 2'b00;
      bit_ff       <= 4'h0;
      hold_cnt_ff  <= 8'h00;
      scl_low_ff   <= 1'b0;
      sda_low_ff   <= 1'b0;
      pend_ff      <= 1'b0;
      pend_val_ff  <= 1'b0;
      addr_ph_ff   <= 1'b0;
      slv_act_ff   <= 1'b0;
      cond_stop_ff <= 1'b0;
    end
    else if (soft_rst)
    begin
      state_ff     <= TWC_IDLE;
      st_ff        <= '0;
      data_ff      <= `TWC_RST_DATA;
      irq_flag_ff  <= 1'b0;
      start_req_ff <= 1'b0;
      stop_req_ff  <= 1'b0;
      master_ff    <= 1'b0;
      scl_low_ff   <= 1'b0;
      sda_low_ff   <= 1'b0;
      pend_ff      <= 1'b0;
      slv_act_ff   <= 1'b0;
    end
    else
    begin
      if (wr_stat)
      begin
        st_ff.byte_done <= 1'b0;
        st_ff.stop      <= 1'b0;
        st_ff.sel       <= 1'b0;
        st_ff.lost      <= 1'b0;
        st_ff.ack_rx    <= 1'b0;
        irq_flag_ff     <= 1'b0;
      end
      if (wr_mode)
      begin
        irq_flag_ff  <= pwdata[`TWC_MODE_IRQ] & irq_flag_ff;
        start_req_ff <= pwdata[`TWC_MODE_START];
        stop_req_ff  <= pwdata[`TWC_MODE_STOP];
      end
      if (wr_data)
        data_ff <= pwdata[7:0];
      if (hold_cnt_ff != 8'h00)
        hold_cnt_ff <= hold_cnt_ff - 8'h01;
      if (pend_ff && hold_cnt_ff == 8'h00)
      begin
        sda_low_ff <= pend_val_ff;
        pend_ff    <= 1'b0;
      end
      if (start_det)
        st_ff.busy <= 1'b1;
      if (stop_det)
        st_ff.busy <= 1'b0;

      if (!en_ff)
      begin
        state_ff   <= TWC_IDLE;
        master_ff  <= 1'b0;
        scl_low_ff <= 1'b0;
        sda_low_ff <= 1'b0;
        pend_ff    <= 1'b0;
      end
      else
      begin
        case (state_ff)
          TWC_IDLE:
          begin
            if (start_req_ff && !st_ff.busy && !start_det)
            begin
              master_ff    <= 1'b1;
              start_req_ff <= 1'b0;
              cond_stop_ff <= 1'b0;
              phase_ff     <= 2'b01;
              cnt_ff       <= high_load;
              state_ff     <= TWC_MCOND;
            end
          end
          TWC_BYTE:
          begin
            if (master_ff)
            begin
              if (scl_low_ff)
              begin
                if (cnt_ff == CNT_ZERO)
                begin
                  scl_low_ff <= 1'b0;
                  cnt_ff     <= high_load;
                end
                else
                  cnt_ff <= cnt_ff - 1'b1;
              end
              else if (scl_s_ff)
              begin
                if (cnt_ff == CNT_ZERO)
                begin
                  scl_low_ff <= 1'b1;
                  cnt_ff     <= low_load;
                end
                else
                  cnt_ff <= cnt_ff - 1'b1;
              end
            end
            else if (scl_low_ff && !pend_ff)
              scl_low_ff <= 1'b0;
            if (scl_rise)
            begin
              bit_ff <= bit_ff + 4'h1;
              if (bit_ff < `TWC_ACK_BIT)
              begin
                data_ff <= {data_ff[6:0], sda_s_ff};
                if (master_ff && tx_bit && !sda_low_ff && !sda_s_ff)
                begin
                  master_ff   <= 1'b0;
                  st_ff.lost  <= 1'b1;
                  irq_flag_ff <= 1'b1;
                  scl_low_ff  <= 1'b1;
                  pend_ff     <= 1'b0;
                  state_ff    <= TWC_HOLD;
                end
              end
              else
                st_ff.ack_rx <= ~sda_s_ff;
            end
            if (scl_fall)
            begin
              pend_ff     <= 1'b1;
              hold_cnt_ff <= hold_ff;
              pend_val_ff <= 1'b0;
              if (bit_ff < `TWC_ACK_BIT)
                pend_val_ff <= tx_bit & ~data_ff[7];
              else if (bit_ff == `TWC_ACK_BIT)
              begin
                if (addr_ph_ff && !master_ff)
                begin
                  if (match && ack_enable_ff)
                  begin
                    pend_val_ff <= 1'b1;
                    slv_act_ff  <= 1'b1;
                  end
                  else
                  begin
                    pend_ff  <= 1'b0;
                    state_ff <= TWC_IDLE;
                  end
                end
                else if (!tx_bit)
                  pend_val_ff <= ack_enable_ff;
              end
              else
              begin
                st_ff.byte_done <= 1'b1;
                irq_flag_ff     <= 1'b1;
                scl_low_ff      <= 1'b1;
                bit_ff          <= 4'h0;
                addr_ph_ff      <= 1'b0;
                state_ff        <= TWC_HOLD;
                if (addr_ph_ff)
                begin
                  st_ff.tx <= master_ff ? ~data_ff[0] : data_ff[0];
                  if (master_ff)
                    st_ff.addr_ack_or_general_call <= st_ff.ack_rx;
                  else
                  begin
                    st_ff.sel   <= 1'b1;
                    st_ff.addr_ack_or_general_call <= (data_ff == `TWC_ADDR_ACK_OR_GENERAL_CALL_ADDR);
                  end
                end
              end
            end
          end
          TWC_HOLD:
          begin
            if (wr_stat)
            begin
              cnt_ff <= low_load;
              if (master_ff && start_req_ff)
              begin
                start_req_ff <= 1'b0;
                cond_stop_ff <= 1'b0;
                phase_ff     <= 2'b00;
                state_ff     <= TWC_MCOND;
              end
              else if (master_ff && stop_req_ff)
              begin
                stop_req_ff  <= 1'b0;
                cond_stop_ff <= 1'b1;
                phase_ff     <= 2'b00;
                state_ff     <= TWC_MCOND;
              end
              else if (!master_ff && !slv_act_ff)
              begin
                scl_low_ff <= 1'b0;
                sda_low_ff <= 1'b0;
                state_ff   <= TWC_IDLE;
              end
              else
              begin
                pend_ff     <= 1'b1;
                pend_val_ff <= st_ff.tx & ~data_ff[7];
                hold_cnt_ff <= hold_ff;
                state_ff    <= TWC_BYTE;
              end
            end
          end
          TWC_MCOND:
          begin
            cnt_ff <= cnt_ff - 1'b1;
            case (phase_ff)
              2'b00:
              begin
                scl_low_ff <= 1'b1;
                sda_low_ff <= cond_stop_ff;
                pend_ff    <= 1'b0;
                if (cnt_ff == CNT_ZERO)
                begin
                  scl_low_ff <= 1'b0;
                  cnt_ff     <= high_load;
                  phase_ff   <= 2'b01;
                end
              end
              2'b01:
              begin
                if (!scl_s_ff)
                  cnt_ff <= cnt_ff;
                else if (cnt_ff == CNT_ZERO)
                begin
                  sda_low_ff <= ~cond_stop_ff;
                  cnt_ff     <= high_load;
                  phase_ff   <= 2'b10;
                end
              end
              default:
              begin
                if (cnt_ff == CNT_ZERO)
                begin
                  if (cond_stop_ff)
                  begin
                    master_ff <= 1'b0;
                    state_ff  <= TWC_IDLE;
                  end
                  else
                  begin
                    scl_low_ff  <= 1'b1;
                    cnt_ff      <= low_load;
                    bit_ff      <= 4'h0;
                    addr_ph_ff  <= 1'b1;
                    st_ff.tx    <= 1'b1;
                    pend_ff     <= 1'b1;
                    pend_val_ff <= ~data_ff[7];
                    hold_cnt_ff <= hold_ff;
                    state_ff    <= TWC_BYTE;
                  end
                end
              end
            endcase
          end
          default:
            state_ff <= TWC_IDLE;
        endcase

        if (start_det && state_ff != TWC_MCOND)
        begin
          master_ff   <= 1'b0;
          slv_act_ff  <= 1'b0;
          st_ff.addr_ack_or_general_call <= 1'b0;
          st_ff.tx    <= 1'b0;
          bit_ff      <= 4'h0;
          addr_ph_ff  <= 1'b1;
          scl_low_ff  <= 1'b0;
          sda_low_ff  <= 1'b0;
          pend_ff     <= 1'b0;
          state_ff    <= TWC_BYTE;
        end
        if (stop_det)
        begin
          st_ff.stop  <= 1'b1;
          irq_flag_ff <= 1'b1;
          master_ff   <= 1'b0;
          slv_act_ff  <= 1'b0;
          scl_low_ff  <= 1'b0;
          sda_low_ff  <= 1'b0;
          pend_ff     <= 1'b0;
          state_ff    <= TWC_IDLE;
        end
      end
    end
  end

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign scl_out  = pin_lo_ff;
  assign sda_out  = pin_lo_ff;
  assign scl_oe_n = ~scl_low_ff;
  assign sda_oe_n = ~sda_low_ff;
  assign irq      = irq_ff;
endmodule : twc_top

// file: verification/tb.sv
// Bench for the two-wire controller: registers over APB, master writes to a stand-in slave.
// Assumes design, package, header and checker are compiled first.
`include "twc_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import twc_pkg::*;
  localparam logic [6:0] PEER = 7'h2A;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        scl_out, scl_oe_n, sda_out, sda_oe_n, irq, peer_oe_n, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  peer_byte, rv;
  logic [15:0] seed;
  int          fails, tests_run;
  wire         scl = scl_oe_n;
  wire         sda = sda_oe_n & peer_oe_n;
  logic [9:0]  ixs [8] = '{`TWC_IDX_OWN_ALT, `TWC_IDX_OWN, `TWC_IDX_MODE, `TWC_IDX_STATUS,
                           `TWC_IDX_LOW, `TWC_IDX_HIGH, `TWC_IDX_HOLD, `TWC_IDX_DATA};
  logic [7:0]  rst_v [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h3F, 8'h01, 8'hFF};
  twc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .scl_in(scl), .scl_out, .scl_oe_n, .sda_in(sda), .sda_out, .sda_oe_n, .irq);
  twc_peer #(.ADDR(PEER)) peer (.pclk, .scl, .sda, .sda_oe_n(peer_oe_n), .rx_byte(peer_byte));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] tx_status(input logic ack);
    return {ack, 1'b1, 3'b000, 2'b11, ack};
  endfunction : tx_status
  task automatic close_out();
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {ix, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rv  = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fails++;
      close_out();
    end
  endtask : apb
  task automatic wait_st(input logic [7:0] m);
    int n;
    n  = 0;
    rv = 8'h00;
    while ((rv & m) == 8'h00 && n < 400)
    begin
      apb(1'b0, `TWC_IDX_STATUS, 8'h00);
      n++;
    end
    if ((rv & m) == 8'h00)
    begin
      fails++;
      close_out();
    end
  endtask : wait_st
  initial
  begin
    fails = 0;
    tests_run = 0;
    seed = 16'h5150;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, ixs[i], 8'h00);
      check("reset value", rst_v[i], rv);
    end
    apb(1'b0, 10'h0D8, 8'h00);
    check("unmapped error", 8'h01, {7'h00, err});
    for (int i = 0; i < 8; i++)
    begin
      if (i == 2 || i == 3)
        continue;
      seed = lfsr(seed);
      apb(1'b1, ixs[i], seed[7:0]);
      apb(1'b0, ixs[i], 8'h00);
      check("register readback", seed[7:0], rv);
    end
    apb(1'b1, `TWC_IDX_OWN, 8'hA4);
    apb(1'b1, `TWC_IDX_LOW, 8'h03);
    apb(1'b1, `TWC_IDX_HIGH, 8'h02);
    apb(1'b1, `TWC_IDX_HOLD, 8'h01);
    apb(1'b1, `TWC_IDX_DATA, 8'h5A);
    apb(1'b1, `TWC_IDX_MODE, 8'h60);
    apb(1'b0, `TWC_IDX_MODE, 8'h00);
    check("mode after soft reset", 8'h40, rv);
    apb(1'b0, `TWC_IDX_DATA, 8'h00);
    check("data after soft reset", 8'hFF, rv);
    apb(1'b0, `TWC_IDX_OWN, 8'h00);
    check("address kept", 8'hA4, rv);
    // Addressed write to the stand-in, one data byte, then stop
    apb(1'b1, `TWC_IDX_DATA, {PEER, 1'b0});
    apb(1'b1, `TWC_IDX_MODE, 8'h59);
    wait_st(8'h40);
    check("address status", tx_status(1'b1), rv);
    check("clock held", 8'h00, {7'h00, scl});
    check("irq raised", 8'h01, {7'h00, irq});
    apb(1'b0, `TWC_IDX_MODE, 8'h00);
    check("mode as master", 8'hDC, rv);
    seed = lfsr(seed);
    apb(1'b1, `TWC_IDX_DATA, seed[7:0]);
    apb(1'b1, `TWC_IDX_STATUS, 8'hFF);
    apb(1'b0, `TWC_IDX_STATUS, 8'h00);
    check("status cleared", 8'h86, rv);
    wait_st(8'h40);
    check("data status", tx_status(1'b1), rv);
    check("byte on wire", seed[7:0], peer_byte);
    apb(1'b1, `TWC_IDX_MODE, 8'h5A);
    apb(1'b1, `TWC_IDX_STATUS, 8'h00);
    wait_st(8'h20);
    check("stop status", 8'h20, rv & 8'h24);
    check("lines idle", 8'h03, {6'h00, scl, sda});
    apb(1'b0, `TWC_IDX_MODE, 8'h00);
    check("master dropped", 8'h00, rv & 8'h07);
    // Unanswered address with the interrupt disabled
    apb(1'b1, `TWC_IDX_STATUS, 8'h00);
    apb(1'b1, `TWC_IDX_DATA, 8'h2A);
    apb(1'b1, `TWC_IDX_MODE, 8'h49);
    wait_st(8'h40);
    check("no ack status", tx_status(1'b0), rv);
    check("irq masked", 8'h00, {7'h00, irq});
    check("clock held", 8'h00, {7'h00, scl});
    apb(1'b1, `TWC_IDX_MODE, 8'h4A);
    apb(1'b1, `TWC_IDX_STATUS, 8'h00);
    wait_st(8'h20);
    check("second stop", 8'h20, rv & 8'h24);
    close_out();
  end
endmodule : tb

// file: verification/twc_peer.sv
// Stand-in slave: acknowledges its own address and then every byte.
// Assumes open-drain lines with pull-ups; the master makes the clock.
module twc_peer
  import twc_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h2A
)
(
  input  wire logic       pclk,
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe_n,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic       hit;
  logic [3:0] bit_cnt;
  logic [7:0] sh;
  initial
  begin
    sda_oe_n = 1'b1;
    scl_q    = 1'b1;
    sda_q    = 1'b1;
    bit_cnt  = 4'h0;
    hit      = 1'b0;
    first    = 1'b0;
    sh       = 8'h00;
    rx_byte  = 8'h00;
  end
  // Acts one cycle after seeing a clock edge, so data never moves with the clock
  always @(posedge pclk)
  begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda)
    begin
      bit_cnt <= 4'hF;
      first   <= 1'b1;
      hit     <= 1'b1;
    end
    else if (scl && !scl_q && bit_cnt < 4'h8)
      sh <= {sh[6:0], sda};
    else if (!scl && scl_q)
    begin
      if (bit_cnt == 4'h7)
      begin
        rx_byte  <= sh;
        hit      <= hit && (!first || sh[7:1] == ADDR);
        sda_oe_n <= !(hit && (!first || sh[7:1] == ADDR));
      end
      if (bit_cnt == 4'h8)
      begin
        sda_oe_n <= 1'b1;
        first    <= 1'b0;
        bit_cnt  <= 4'h0;
      end
      else
        bit_cnt <= bit_cnt + 4'h1;
    end
  end
endmodule : twc_peer

// file: verification/twc_top_props.sv
// Checker for the two-wire controller top level.
// Assumes it is bound to twc_top and sees only its ports.
`include "twc_regs.svh"
module twc_top_props
  import twc_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Two-wire pins
  input wire logic        scl_in,
  input wire logic        scl_out,
  input wire logic        scl_oe_n,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0]  idx;
  logic        wr_ev;
  logic        mapped;
  logic        en_ff;
  logic        irqen_ff;
  logic [7:0]  low_ff;
  logic [7:0]  high_ff;
  logic [10:0] lo_cnt_ff;
  logic [10:0] hi_cnt_ff;
  assign idx    = paddr[11:2];
  assign wr_ev  = psel & penable & pready & pwrite;
  assign mapped = idx inside {`TWC_IDX_OWN_ALT, `TWC_IDX_OWN, [`TWC_IDX_MODE:`TWC_IDX_DATA]};
  // Shadow of the configuration written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_ff    <= 1'b0;
      irqen_ff <= 1'b0;
      low_ff   <= `TWC_RST_LOW;
      high_ff  <= `TWC_RST_HIGH;
    end
    else if (wr_ev)
    begin
      if (idx == `TWC_IDX_MODE)
      begin
        en_ff    <= pwdata[`TWC_MODE_EN];
        irqen_ff <= pwdata[`TWC_MODE_IRQEN];
      end
      if (idx == `TWC_IDX_LOW)
        low_ff <= pwdata[7:0];
      if (idx == `TWC_IDX_HIGH)
        high_ff <= pwdata[7:0];
    end
  end
  // Length of the current low and released stretch of the driven clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lo_cnt_ff <= 11'h000;
      hi_cnt_ff <= 11'h000;
    end
    else
    begin
      lo_cnt_ff <= scl_oe_n ? 11'h000 : lo_cnt_ff + 11'h001;
      if (!scl_oe_n)
        hi_cnt_ff <= 11'h000;
      else if (hi_cnt_ff != 11'h7FF)
        hi_cnt_ff <= hi_cnt_ff + 11'h001;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_on_unmapped: assert property (pready |-> pslverr == (!mapped || paddr[1:0] != 2'b00))
    else $error("pslverr wrong for address");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
    else $error("read data outside answer");
  a_srst_reads_zero: assert property (pready && !pwrite && idx == `TWC_IDX_MODE |-> !prdata[5])
    else $error("soft reset bit read back set");
  a_irq_gated: assert property (irq |-> $past(irqen_ff))
    else $error("irq while disabled");
  a_off_released: assert property (!en_ff && !$past(en_ff) && !$past(en_ff, 2) |-> scl_oe_n && sda_oe_n)
    else $error("lines driven while disabled");
  a_status_releases: assert property (wr_ev && idx == `TWC_IDX_STATUS && !scl_oe_n |-> ##[1:1000] scl_oe_n)
    else $error("held clock not released");
  a_scl_low_len: assert property ($rose(scl_oe_n) |-> lo_cnt_ff >= {1'b0, low_ff, 2'b00} + 11'h001)
    else $error("clock low period short");
  a_scl_high_len: assert property ($fell(scl_oe_n) |-> hi_cnt_ff >= {1'b0, high_ff, 2'b00} + 11'h003)
    else $error("clock high period short");
  a_pins_open_drain: assert property (!scl_out && !sda_out)
    else $error("pin driven high");
endmodule : twc_top_props
bind twc_top twc_top_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .scl_in, .scl_out, .scl_oe_n, .sda_in, .sda_out, .sda_oe_n, .irq);
